// *** rtl/addc_pkg.sv ***
// Purpose: Constants for the antenna driver and damping controller.
// Assumes: CLK at 40 MHz, FC_TICK marks one recovered carrier period.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
package addc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDC_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  ADDC_WAKE_OFS   = 8'h04;
    localparam logic [7:0]  ADDC_STATUS_OFS = 8'h08;
    localparam logic [13:0] ADDC_CTRL_RST   = 14'h0000;
    localparam logic [4:0]  ADDC_WAKE_RST   = 5'h00;
    // CTRL fields
    localparam int ADDC_C_SINGLE  = 0;
    localparam int ADDC_C_INPHASE = 1;
    localparam int ADDC_C_IDLE_LO = 2;
    localparam int ADDC_C_MANCH   = 4;
    localparam int ADDC_C_RATE_LO = 5;
    localparam int ADDC_C_DRES_LO = 7;
    localparam int ADDC_C_ABS     = 10;
    localparam int ADDC_C_LVL_LO  = 11;
    // WAKE fields
    localparam int ADDC_W_EN      = 0;
    localparam int ADDC_W_LP      = 1;
    localparam int ADDC_W_THR_LO  = 2;
    localparam int ADDC_W_SLEEP   = 5;
    // Idle state codes
    localparam logic [1:0] ADDC_IDLE_SPLIT = 2'h0;
    localparam logic [1:0] ADDC_IDLE_HIGH  = 2'h1;
    localparam logic [1:0] ADDC_IDLE_LOW   = 2'h2;
    // Rate codes
    localparam logic [1:0] ADDC_RATE_106 = 2'h0;
    localparam logic [1:0] ADDC_RATE_212 = 2'h1;
    // ------------------------------------------------------------
    // Reply timing, in carrier periods and subcarrier halves
    // ------------------------------------------------------------
    localparam logic [3:0] ADDC_FC_PER_HALF = 4'h8;
    localparam logic [3:0] ADDC_DAMP_FC     = 4'h3;
    localparam logic [4:0] ADDC_HALVES_106  = 5'h10;
    localparam logic [4:0] ADDC_HALVES_212  = 5'h08;
    localparam logic [4:0] ADDC_HALVES_424  = 5'h04;
    localparam logic [4:0] ADDC_MAN_HALF    = 5'h08;
    // Absolute supply ladder in millivolts
    localparam logic [11:0] ADDC_ABS_TOP_MV  = 12'h960;
    localparam logic [11:0] ADDC_ABS_STEP_MV = 12'h320;
    // ------------------------------------------------------------
    // Frequency check window
    // ------------------------------------------------------------
    localparam int ADDC_CLK_MHZ   = 40;
    localparam int ADDC_WIN_NS    = 6400;
    localparam int ADDC_FC_KHZ    = 13560;
    localparam int ADDC_WIN_CYC   = ADDC_WIN_NS * ADDC_CLK_MHZ / 1000;
    localparam int ADDC_EXP_EDGES = ADDC_WIN_NS * ADDC_FC_KHZ / 1000000;
    localparam int ADDC_TOL_EDGES = 8;
    localparam logic [7:0] ADDC_EDGE_MIN =
        8'(ADDC_EXP_EDGES - ADDC_TOL_EDGES);
    localparam logic [7:0] ADDC_EDGE_MAX =
        8'(ADDC_EXP_EDGES + ADDC_TOL_EDGES);
    localparam logic [8:0] ADDC_WIN_LAST = 9'(ADDC_WIN_CYC - 1);
    typedef enum logic [1:0] {
        ADDC_WU_SLEEP, ADDC_WU_CHECK, ADDC_WU_ACTIVE
    } addc_wu_state_type;
endpackage

// *** rtl/addc_freq_check.sv ***
// Purpose: Counts receiver edges over a fixed window.
// Assumes: EDGE is a one-cycle pulse per carrier cycle seen.
// Notes:   Ok only when the count lands near 13.56 MHz.
`timescale 1ns/1ps
`default_nettype none
module addc_freq_check
    import addc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic       edge_in,
    output var  logic       done,
    output var  logic       ok,
    output var  logic [7:0] count
);
    logic [8:0] win_reg;
    logic [7:0] cnt_reg;
    logic       run_reg;
    // ------------------------------------------------------------
    // Window and edge count
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            win_reg <= 9'h000;
            cnt_reg <= 8'h00;
            run_reg <= 1'b0;
            done    <= 1'b0;
            ok      <= 1'b0;
            count   <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start) begin
                win_reg <= 9'h000;
                cnt_reg <= 8'h00;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                // Saturate so a noisy input cannot wrap into range
                if (edge_in && cnt_reg != 8'hff) begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
                if (win_reg == ADDC_WIN_LAST) begin
                    run_reg <= 1'b0;
                    done    <= 1'b1;
                    count   <= cnt_reg;
                    ok      <= cnt_reg >= ADDC_EDGE_MIN &&
                               cnt_reg <= ADDC_EDGE_MAX;
                end else begin
                    win_reg <= win_reg + 9'h001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/addc_ctrl.sv ***
// Purpose: Antenna driver modes, reply damping/resync, wake-up gate.
// Assumes: FC_PHASE and FC_TICK come from the carrier PLL, in step
//          with CLK; TX bits are offered on a valid/ready pair.
// Notes:   APB slave with zero wait states, PSLVERR on bad address.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module addc_ctrl
    import addc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        FC_TICK,
    input  wire logic        FC_PHASE,
    input  wire logic        TX_VALID,
    input  wire logic        TX_BIT,
    output var  logic        TX_READY,
    output var  logic        FIRST_ANTENNA_OUTPUT,
    output var  logic        FIRST_ANTENNA_OE_N,
    output var  logic        SECOND_ANTENNA_OUTPUT,
    output var  logic        SECOND_ANTENNA_OE_N,
    output var  logic        DAMP_DRIVER_EN,
    output var  logic [2:0]  DAMP_RES_SEL,
    output var  logic        RX_INPUT_DAMP_EN,
    output var  logic        AUX_DAMP_EN,
    output var  logic        PLL_SYNC_EN,
    output var  logic        SUPPLY_ABS_MODE,
    output var  logic [1:0]  SUPPLY_LEVEL,
    output var  logic [11:0] SUPPLY_TARGET_MV,
    input  wire logic        WU_DETECT,
    input  wire logic        WU_LP_DETECT,
    input  wire logic        RX_EDGE,
    output var  logic        WU_GAIN_EN,
    output var  logic        WU_LP_EN,
    output var  logic [2:0]  WU_THRESHOLD,
    output var  logic        SYSTEM_ACTIVE
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] halves_per_bit(input logic [1:0] r);
        if (r == ADDC_RATE_106) begin
            return ADDC_HALVES_106;
        end else if (r == ADDC_RATE_212) begin
            return ADDC_HALVES_212;
        end
        return ADDC_HALVES_424;
    endfunction

    function automatic logic [11:0] abs_mv(input logic [1:0] lvl);
        // Level 0 is the main supply itself, reported as zero
        if (lvl == 2'h0) begin
            return 12'h000;
        end
        return ADDC_ABS_TOP_MV - 12'(ADDC_ABS_STEP_MV * (lvl - 2'h1));
    endfunction

    logic [13:0]       ctrl_reg;
    logic [4:0]        wake_reg;
    logic              frame_reg;
    logic [3:0]        fc_cnt_reg;
    logic [4:0]        half_reg;
    logic              bit_reg;
    logic              sc_phase_reg;
    logic              prev_mod_reg;
    addc_wu_state_type wu_state_reg;
    logic              fchk_start_reg;
    logic              fchk_done;
    logic              fchk_ok;
    logic [7:0]        fchk_count;
    logic              mod_reg;
    logic              damp_reg;
    logic              sync_reg;

    logic       single_mode;
    logic       in_phase;
    logic [1:0] idle_sel;
    logic       manch;
    logic [1:0] rate;
    logic       wu_en;
    logic       wu_lp;
    logic       sleep_cmd;
    logic       setup;
    logic       wr_en;
    logic       mapped;
    logic       last_fc;
    logic       last_half;
    logic       mod_now;
    logic       damp_now;
    logic       sync_now;
    logic       start_frame;

    assign single_mode = ctrl_reg[ADDC_C_SINGLE];
    assign in_phase    = ctrl_reg[ADDC_C_INPHASE];
    assign idle_sel    = ctrl_reg[ADDC_C_IDLE_LO +: 2];
    assign manch       = ctrl_reg[ADDC_C_MANCH];
    assign rate        = ctrl_reg[ADDC_C_RATE_LO +: 2];
    assign wu_en       = wake_reg[ADDC_W_EN];
    assign wu_lp       = wake_reg[ADDC_W_LP];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup  = PSEL && !PENABLE;
    assign mapped = PADDR == ADDC_CTRL_OFS || PADDR == ADDC_WAKE_OFS ||
                    PADDR == ADDC_STATUS_OFS;
    assign wr_en  = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign sleep_cmd = wr_en && PADDR == ADDC_WAKE_OFS &&
                       PWDATA[ADDC_W_SLEEP];

    // Writable configuration; status is read only
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_reg <= ADDC_CTRL_RST;
            wake_reg <= ADDC_WAKE_RST;
        end else if (wr_en && PADDR == ADDC_CTRL_OFS) begin
            ctrl_reg <= PWDATA[13:0];
        end else if (wr_en && PADDR == ADDC_WAKE_OFS) begin
            wake_reg <= PWDATA[4:0];
        end
    end

    // Read data captured in setup so it is stable in access
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            unique case (PADDR)
                ADDC_CTRL_OFS:   PRDATA <= {18'h00000, ctrl_reg};
                ADDC_WAKE_OFS:   PRDATA <= {27'h0000000, wake_reg};
                ADDC_STATUS_OFS: PRDATA <= {16'h0000, fchk_count,
                    1'b0, wu_state_reg, sync_reg, damp_reg,
                    mod_reg, frame_reg, SYSTEM_ACTIVE};
                default:         PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reply sequencer
    // ------------------------------------------------------------
    assign last_fc   = fc_cnt_reg == ADDC_FC_PER_HALF - 4'h1;
    assign last_half = half_reg == halves_per_bit(rate) - 5'h01;
    assign start_frame = !frame_reg && SYSTEM_ACTIVE && FC_TICK &&
                         TX_VALID;
    // Bits are offered at carrier tick on each bit boundary
    assign TX_READY = FC_TICK && ((!frame_reg && SYSTEM_ACTIVE) ||
                      (frame_reg && last_fc && last_half));

    // Subcarrier half carries transmission or is left empty
    always_comb begin
        if (!frame_reg) begin
            mod_now = 1'b0;
        end else if (manch && rate == ADDC_RATE_106) begin
            mod_now = !half_reg[0] && (bit_reg ? half_reg < ADDC_MAN_HALF
                      : half_reg >= ADDC_MAN_HALF);
        end else begin
            mod_now = !(half_reg[0] ^ sc_phase_reg);
        end
    end

    // Damp first after a driven half, then resync the remainder
    assign damp_now = frame_reg && !mod_now && prev_mod_reg &&
                      fc_cnt_reg < ADDC_DAMP_FC;
    assign sync_now = frame_reg && !mod_now && !damp_now;

    // Position inside the frame, advanced once per carrier period
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            frame_reg    <= 1'b0;
            fc_cnt_reg   <= 4'h0;
            half_reg     <= 5'h00;
            bit_reg      <= 1'b0;
            sc_phase_reg <= 1'b0;
            prev_mod_reg <= 1'b0;
        end else if (start_frame) begin
            frame_reg    <= 1'b1;
            bit_reg      <= TX_BIT;
            fc_cnt_reg   <= 4'h0;
            half_reg     <= 5'h00;
            sc_phase_reg <= 1'b0;
            prev_mod_reg <= 1'b0;
        end else if (frame_reg && FC_TICK) begin
            if (!last_fc) begin
                fc_cnt_reg <= fc_cnt_reg + 4'h1;
            end else begin
                fc_cnt_reg   <= 4'h0;
                prev_mod_reg <= mod_now;
                if (!last_half) begin
                    half_reg <= half_reg + 5'h01;
                end else if (TX_VALID) begin
                    half_reg <= 5'h00;
                    bit_reg  <= TX_BIT;
                    // Phase flip repeats the last half: doubled gap, or doubled driven half when the phase was set
                    if (TX_BIT != bit_reg) begin
                        sc_phase_reg <= !sc_phase_reg;
                    end
                end else begin
                    // No further bit: frame ends, drivers go idle
                    frame_reg <= 1'b0;
                    half_reg  <= 5'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Driver outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FIRST_ANTENNA_OUTPUT  <= 1'b1;
            FIRST_ANTENNA_OE_N    <= 1'b0;
            SECOND_ANTENNA_OUTPUT <= 1'b0;
            SECOND_ANTENNA_OE_N   <= 1'b0;
        end else if (damp_now) begin
            FIRST_ANTENNA_OE_N  <= 1'b1;
            SECOND_ANTENNA_OE_N <= 1'b1;
        end else if (mod_now) begin
            FIRST_ANTENNA_OUTPUT <= FC_PHASE;
            FIRST_ANTENNA_OE_N   <= 1'b0;
            SECOND_ANTENNA_OUTPUT <= single_mode ? FC_PHASE
                                                 : !FC_PHASE;
            SECOND_ANTENNA_OE_N  <= single_mode && !in_phase;
        end else begin
            // Second state and gaps rest at idle levels, no carrier
            FIRST_ANTENNA_OUTPUT  <= idle_sel != ADDC_IDLE_LOW;
            SECOND_ANTENNA_OUTPUT <= idle_sel == ADDC_IDLE_HIGH;
            FIRST_ANTENNA_OE_N    <= 1'b0;
            SECOND_ANTENNA_OE_N   <= single_mode && !in_phase;
        end
    end

    // Damping paths and sync strobe move together
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mod_reg          <= 1'b0;
            damp_reg         <= 1'b0;
            sync_reg         <= 1'b0;
            DAMP_DRIVER_EN   <= 1'b0;
            RX_INPUT_DAMP_EN <= 1'b0;
            AUX_DAMP_EN      <= 1'b0;
            PLL_SYNC_EN      <= 1'b0;
        end else begin
            mod_reg          <= mod_now;
            damp_reg         <= damp_now;
            sync_reg         <= sync_now;
            DAMP_DRIVER_EN   <= damp_now;
            RX_INPUT_DAMP_EN <= damp_now;
            AUX_DAMP_EN      <= damp_now;
            PLL_SYNC_EN      <= sync_now;
        end
    end

    // Static settings mirrored to the analog side
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            DAMP_RES_SEL     <= 3'h0;
            SUPPLY_ABS_MODE  <= 1'b0;
            SUPPLY_LEVEL     <= 2'h0;
            SUPPLY_TARGET_MV <= 12'h000;
            WU_THRESHOLD     <= 3'h0;
        end else begin
            DAMP_RES_SEL    <= ctrl_reg[ADDC_C_DRES_LO +: 3];
            SUPPLY_ABS_MODE <= ctrl_reg[ADDC_C_ABS];
            SUPPLY_LEVEL    <= ctrl_reg[ADDC_C_LVL_LO +: 2];
            // Relative mode leaves scaling to the regulator
            SUPPLY_TARGET_MV <= ctrl_reg[ADDC_C_ABS] ?
                abs_mv(ctrl_reg[ADDC_C_LVL_LO +: 2]) : 12'h000;
            WU_THRESHOLD    <= wake_reg[ADDC_W_THR_LO +: 3];
        end
    end

    // ------------------------------------------------------------
    // Wake-up gate
    // ------------------------------------------------------------
    addc_freq_check u_freq (
        .clk     (CLK),
        .reset   (RESET),
        .start   (fchk_start_reg),
        .edge_in (RX_EDGE),
        .done    (fchk_done),
        .ok      (fchk_ok),
        .count   (fchk_count)
    );

    // Sleep only when enabled; a detection must pass the check
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wu_state_reg   <= ADDC_WU_ACTIVE;
            fchk_start_reg <= 1'b0;
        end else begin
            fchk_start_reg <= 1'b0;
            unique case (wu_state_reg)
                ADDC_WU_ACTIVE: begin
                    if (sleep_cmd && wu_en) begin
                        wu_state_reg <= ADDC_WU_SLEEP;
                    end
                end
                ADDC_WU_SLEEP: begin
                    if (!wu_en) begin
                        wu_state_reg <= ADDC_WU_ACTIVE;
                    end else if (wu_lp ? WU_LP_DETECT
                                       : WU_DETECT) begin
                        wu_state_reg   <= ADDC_WU_CHECK;
                        fchk_start_reg <= 1'b1;
                    end
                end
                ADDC_WU_CHECK: begin
                    if (!wu_en) begin
                        wu_state_reg <= ADDC_WU_ACTIVE;
                    end else if (fchk_done) begin
                        wu_state_reg <= fchk_ok ? ADDC_WU_ACTIVE
                                                : ADDC_WU_SLEEP;
                    end
                end
                default: wu_state_reg <= ADDC_WU_ACTIVE;
            endcase
        end
    end

    // Detector enables derived from the gate state
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SYSTEM_ACTIVE <= 1'b1;
            WU_GAIN_EN    <= 1'b0;
            WU_LP_EN      <= 1'b0;
        end else begin
            SYSTEM_ACTIVE <= wu_state_reg == ADDC_WU_ACTIVE;
            WU_GAIN_EN <= wu_state_reg != ADDC_WU_ACTIVE && !wu_lp;
            WU_LP_EN   <= wu_state_reg != ADDC_WU_ACTIVE && wu_lp;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [3:0] damp_fc_reg;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            damp_fc_reg <= 4'h0;
        end else if (!damp_now) begin
            damp_fc_reg <= 4'h0;
        end else if (FC_TICK) begin
            damp_fc_reg <= damp_fc_reg + 4'h1;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_DAMP_TRISTATE: assert property (
        DAMP_DRIVER_EN |-> FIRST_ANTENNA_OE_N && SECOND_ANTENNA_OE_N)
        else $error("main drivers not off during damping");
    AST_DAMP_PATHS: assert property (
        DAMP_DRIVER_EN == RX_INPUT_DAMP_EN &&
        AUX_DAMP_EN == RX_INPUT_DAMP_EN)
        else $error("damping paths disagree");
    AST_NO_OVERLAP: assert property (
        !(PLL_SYNC_EN && DAMP_DRIVER_EN))
        else $error("sync overlaps damping");
    AST_DAMP_AFTER_MOD: assert property (
        $fell(mod_reg) && frame_reg |-> damp_reg)
        else $error("no damping after modulated half");
    AST_DAMP_LEN: assert property (
        damp_fc_reg <= ADDC_DAMP_FC)
        else $error("damping longer than three carrier periods");
    AST_SYNC_AFTER_DAMP: assert property (
        $fell(damp_reg) && frame_reg && !mod_reg |-> sync_reg)
        else $error("sync missing after damping");
    AST_DIFF_DRIVE: assert property (
        mod_reg && !single_mode && !FIRST_ANTENNA_OE_N |->
        SECOND_ANTENNA_OUTPUT != FIRST_ANTENNA_OUTPUT)
        else $error("differential outputs not opposite");
    AST_SINGLE_INPHASE: assert property (
        mod_reg && single_mode && in_phase |->
        SECOND_ANTENNA_OUTPUT == FIRST_ANTENNA_OUTPUT)
        else $error("single mode outputs not in phase");
    AST_WAKE_CHECKED: assert property (
        $rose(SYSTEM_ACTIVE) && $past(wu_en, 2) |->
        $past(fchk_ok, 2))
        else $error("woke without frequency confirmation");
    AST_LP_NO_GAIN: assert property (
        WU_LP_EN |-> !WU_GAIN_EN)
        else $error("gain stage on in low power mode");
    AST_SLEEP_NO_TX: assert property (
        !SYSTEM_ACTIVE && !frame_reg |-> !TX_READY)
        else $error("reply taken while asleep");

    COV_DAMP_SYNC: cover property (damp_reg ##[1:8] sync_reg);
    COV_PHASE_FLIP: cover property (mod_reg [*2] ##1 damp_reg);
    COV_WAKE: cover property (wu_state_reg == ADDC_WU_CHECK
        ##[1:300] SYSTEM_ACTIVE);
endmodule
`default_nettype wire

// *** testbench/addc_reader_model.sv ***
// Purpose: Reader field model: carrier ticks as the PLL would see them.
// Assumes: per is the carrier period in CLK cycles, 3 near 13.56 MHz.
// Notes:   No field, no ticks: the carrier stands still.
`timescale 1ns/1ps
`default_nettype none
module addc_reader_model (
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       field,
    input  wire logic [3:0] per,
    output var  logic       fc_tick,
    output var  logic       fc_phase
);
    logic [3:0] cnt_reg;
    // Divider parked at zero while the reader is away
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cnt_reg <= 4'h0;
            fc_tick <= 1'b0;
        end else begin
            cnt_reg <= (!field || cnt_reg >= per - 4'h1) ? 4'h0
                                                         : cnt_reg + 4'h1;
            fc_tick <= field && cnt_reg == 4'h0;
        end
    end
    assign fc_phase = cnt_reg < 4'h2;
endmodule
`default_nettype wire

// *** testbench/addc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the driver and damping controller.
// Assumes: Zero-wait APB slave; reader model supplies the carrier.
// Notes:   A monitor checks every damping run during replies.
`timescale 1ns/1ps
`default_nettype none
module addc_ctrl_tb;
    import addc_pkg::*;
    logic CLK, RESET, PSEL, PENABLE, PWRITE, TX_VALID, TX_BIT, field, er;
    logic PREADY, PSLVERR, TX_READY, FC_TICK, FC_PHASE, PLL_SYNC_EN;
    logic FIRST_ANTENNA_OUTPUT, FIRST_ANTENNA_OE_N, SECOND_ANTENNA_OUTPUT;
    logic SECOND_ANTENNA_OE_N, DAMP_DRIVER_EN, RX_INPUT_DAMP_EN, AUX_DAMP_EN;
    logic SUPPLY_ABS_MODE, WU_GAIN_EN, WU_LP_EN, SYSTEM_ACTIVE;
    logic [1:0]  SUPPLY_LEVEL;
    logic [2:0]  DAMP_RES_SEL, WU_THRESHOLD;
    logic [3:0]  per;
    logic [7:0]  PADDR;
    logic [11:0] SUPPLY_TARGET_MV;
    logic [31:0] PWDATA, PRDATA, rd, dn, dseen;
    int          n_fail = 0, checks = 0;
    wire logic   WU_DETECT = field, WU_LP_DETECT = field, RX_EDGE = FC_TICK;
    addc_ctrl i_dut (.*);
    addc_reader_model i_reader (.CLK, .RESET, .field, .per,
        .fc_tick(FC_TICK), .fc_phase(FC_PHASE));
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic nap(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // One APB transfer; waits on PREADY, bounded by the watchdog
    task automatic apb(input logic        w,
                       input logic [7:0]  a,
                       input logic [31:0] d);
        @(posedge CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        {rd, er} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'b00;
    endtask
    // Offer n reply bits, toggling the value at each take
    task automatic tx(input int n, input int fc_per_bit);
        int t;
        TX_VALID <= 1'b1;
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(posedge CLK);
                t += FC_TICK;
            end while (!(TX_READY === 1'b1 && FC_TICK === 1'b1));
            if (i > 0)
                chk(t, fc_per_bit);
            TX_BIT <= ~TX_BIT;
        end
        TX_VALID <= 1'b0;
        nap(1200);
    endtask
    // Damping must silence the mains and never meet a resync window
    always @(posedge CLK) begin
        if (DAMP_DRIVER_EN === 1'b1) begin
            chk({PLL_SYNC_EN, FIRST_ANTENNA_OE_N, SECOND_ANTENNA_OE_N,
                RX_INPUT_DAMP_EN, AUX_DAMP_EN}, 32'h0f);
            dn = dn + FC_TICK;
        end else if (dn != 0) begin
            chk(dn, ADDC_DAMP_FC);
            dseen = dseen + 1;
            dn = 0;
        end
    end
    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {RESET, PSEL, PENABLE, PWRITE, TX_VALID, TX_BIT, field} = 7'h40;
        {PADDR, PWDATA, per, dn, dseen} = '0;
        repeat (12) @(posedge CLK);
        chk({FIRST_ANTENNA_OUTPUT, SECOND_ANTENNA_OUTPUT, FIRST_ANTENNA_OE_N,
            SECOND_ANTENNA_OE_N, SYSTEM_ACTIVE}, 32'h11);
        RESET <= 1'b0;
        apb(0, ADDC_CTRL_OFS, 0);
        chk(rd, 32'(ADDC_CTRL_RST));
        apb(1, 8'h0c, 32'h5);
        chk(er, 1);
        // Idle codes split, both high, both low
        for (int i = 0; i < 3; i++) begin
            apb(1, ADDC_CTRL_OFS, 32'(i) << ADDC_C_IDLE_LO);
            nap(3);
            chk({FIRST_ANTENNA_OUTPUT, SECOND_ANTENNA_OUTPUT},
                i == 0 ? 32'h2 : (i == 1 ? 32'h3 : 32'h0));
        end
        // Single drive, second output held inactive
        apb(1, ADDC_CTRL_OFS, 32'h1);
        nap(3);
        chk({FIRST_ANTENNA_OE_N, SECOND_ANTENNA_OE_N}, 32'h1);
        for (int l = 1; l < 4; l++) begin
            apb(1, ADDC_CTRL_OFS, (l << ADDC_C_LVL_LO) |
                (l << ADDC_C_DRES_LO) | (1 << ADDC_C_ABS));
            nap(3);
            chk(SUPPLY_TARGET_MV,
                ADDC_ABS_TOP_MV - 12'(l - 1) * ADDC_ABS_STEP_MV);
            chk({SUPPLY_ABS_MODE, SUPPLY_LEVEL}, 32'h4 | l);
            chk(DAMP_RES_SEL, l);
        end
        // Enable first: the sleep command needs a stored enable
        apb(1, ADDC_WAKE_OFS, 32'h03);
        apb(1, ADDC_WAKE_OFS, 32'h23);
        nap(4);
        chk({SYSTEM_ACTIVE, WU_GAIN_EN, WU_LP_EN}, 32'h1);
        apb(1, ADDC_WAKE_OFS, 32'h35);
        nap(4);
        chk({SYSTEM_ACTIVE, WU_GAIN_EN, WU_THRESHOLD}, 32'h0d);
        apb(0, ADDC_WAKE_OFS, 0);
        chk(rd, 32'h15);
        @(posedge CLK);
        {field, per} <= 5'h16;
        nap(800);
        chk(SYSTEM_ACTIVE, 0);
        @(posedge CLK);
        per <= 4'h3;
        nap(800);
        chk(SYSTEM_ACTIVE, 1);
        apb(0, ADDC_STATUS_OFS, 0);
        chk(rd & 32'hff, 32'h41);
        apb(1, ADDC_CTRL_OFS, 32'h40);
        tx(4, 32);
        // Single drive with the second output in phase
        apb(1, ADDC_CTRL_OFS, 32'h43);
        tx(2, 32);
        apb(1, ADDC_CTRL_OFS, 32'h10);
        tx(2, 128);
        chk(dseen > 4, 1);
        final_report;
    end
    initial begin
        repeat (30000) @(posedge CLK);
        n_fail++;
        final_report;
    end
endmodule
`default_nettype wire
